/* File: rtl/mlcd_panel.sv */
// Notes on behaviour
// RULE_01 - Both mode bits low: memory held
// RULE_02 - Clear bit alone: erase all pixels white
// RULE_03 - Update bit high rewrites, low holds
// RULE_04 - Serial mode: electrode follows polarity bit
// RULE_05 - External mode ignores serial polarity bit
// RULE_06 - Frame select low clears mode bits
// RULE_07 - Source pin picks serial or external polarity
// RULE_08 - Toggle rising edge inverts pending polarity
// RULE_09 - Pending polarity applied at frame-select fall
// RULE_10 - Host gives toggle a constant period; mlcd_host forwards ext_toggle_in unchanged
// RULE_11 - Host balances serial polarity intervals; mlcd_host sends req_polarity as given
// RULE_12 - Dummy bits ignored, sent low
// RULE_13 - Seven-bit line address, LSB first, 1-96
// RULE_14 - Store 96 pixel bits, low black
// RULE_15 - Several lines per frame in update mode
// RULE_16 - Mode, then address/pixels/dummy per line
`timescale 1ns/10ps
`default_nettype none
module mlcd_panel
  import mlcd_pkg::*;
#(
  parameter int LINES  = mlcd_pkg::LINE_COUNT,
  parameter int PIXELS = mlcd_pkg::PIXELS_PER_LINE
) (
  mlcd_link_if.panel             link,
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [6:0]        rd_line,
  output logic [PIXELS-1:0]      rd_pixels,
  output logic                   common_electrode_level,
  output logic                   update_select_bit,
  output logic                   clear_all_bit
);
  import mlcd_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Link domain: shifts on serial_clk rising edge, reset by frame_select low
  logic                   frame_active;
  assign frame_active = link.frame_select;

  mlcd_rx_state_t         rx_state_reg;
  logic [6:0]             bit_cnt_reg;
  logic [MODE_BITS-1:0]   mode_reg;
  logic [6:0]             addr_reg;
  logic [PIXELS-1:0]      shift_reg;
  logic [LINES-1:0][PIXELS-1:0] mem_reg;
  logic                   serial_pol_reg;
  logic                   clear_done_reg;

  // Frame select low is an async clear of the mode bits
  always_ff @(posedge link.serial_clk or negedge frame_active) begin
    if (!frame_active) begin
      rx_state_reg <= MLCD_RX_MODE;
      bit_cnt_reg  <= 7'h00;
      mode_reg     <= '0; // see RULE_06
      addr_reg     <= 7'h00;
      shift_reg    <= '0;
    end else begin
      unique case (rx_state_reg)
        MLCD_RX_MODE: begin
          mode_reg[bit_cnt_reg[1:0]] <= link.serial_data;
          if (bit_cnt_reg == 7'(MODE_BITS - 1)) begin
            bit_cnt_reg  <= 7'h00;
            rx_state_reg <= MLCD_RX_MDUM;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
          end
        end
        MLCD_RX_MDUM: begin
          // Content ignored; see RULE_12
          if (bit_cnt_reg == 7'(MODE_DUMMY_BITS - 1)) begin
            bit_cnt_reg  <= 7'h00;
            rx_state_reg <= MLCD_RX_ADDR;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
          end
        end
        MLCD_RX_ADDR: begin
          // Eighth slot is the spare; writing it would fall off the register
          if (bit_cnt_reg < 7'(ADDR_BITS)) begin
            addr_reg[bit_cnt_reg[2:0]] <= link.serial_data; // see RULE_13
          end
          if (bit_cnt_reg == 7'(ADDR_BITS)) begin
            bit_cnt_reg  <= 7'h00;
            rx_state_reg <= MLCD_RX_PIX;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
          end
        end
        MLCD_RX_PIX: begin
          shift_reg[bit_cnt_reg] <= link.serial_data; // see RULE_14
          if (bit_cnt_reg == 7'(PIXELS - 1)) begin
            bit_cnt_reg  <= 7'h00;
            rx_state_reg <= MLCD_RX_LDUM;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
          end
        end
        MLCD_RX_LDUM: begin
          if (bit_cnt_reg == 7'(LINE_DUMMY_BITS - 1)) begin
            bit_cnt_reg  <= 7'h00;
            rx_state_reg <= MLCD_RX_ADDR; // see RULE_15
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
          end
        end
        default: rx_state_reg <= MLCD_RX_MODE;
      endcase
    end
  end

  // Address field is 8 slots here: 7 address bits then one spare
  // Pixel memory; no reset pin, so contents start unknown
  // A line lands at its first dummy bit, once all its pixels are in
  always_ff @(posedge link.serial_clk) begin
    if (frame_active) begin
      if (rx_state_reg == MLCD_RX_MDUM && bit_cnt_reg == 7'h00 &&
          !mode_reg[UPDATE_IDX] && mode_reg[CLEAR_IDX]) begin
        for (int i = 0; i < LINES; i++) begin
          mem_reg[i] <= {PIXELS{PIXEL_WHITE}}; // see RULE_02
        end
      end else if (rx_state_reg == MLCD_RX_LDUM && bit_cnt_reg == 7'h00 &&
                   mode_reg[UPDATE_IDX] && // see RULE_03
                   addr_reg >= FIRST_LINE && addr_reg <= LAST_LINE) begin
        mem_reg[addr_reg - FIRST_LINE] <= shift_reg;
      end
      // Otherwise memory held; see RULE_01
    end
  end

  // Serial polarity bit captured after the mode field
  always_ff @(posedge link.serial_clk) begin
    if (frame_active && rx_state_reg == MLCD_RX_MDUM && bit_cnt_reg == 7'h00) begin
      serial_pol_reg <= mode_reg[POLARITY_IDX];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Polarity logic, sampled in ref_clk domain
  logic [2:0] toggle_sync_reg;
  logic [2:0] scs_sync_reg;
  logic [1:0] src_sync_reg;
  logic [1:0] upd_sync_reg;
  logic [1:0] clr_sync_reg;
  logic [1:0] spol_sync_reg;
  logic       pending_polarity;
  logic       ext_mode;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_sync_reg <= 3'h0;
      scs_sync_reg    <= 3'h0;
      src_sync_reg    <= 2'h0;
      upd_sync_reg    <= 2'h0;
      clr_sync_reg    <= 2'h0;
      spol_sync_reg   <= 2'h0;
    end else begin
      // Third stage of toggle and frame select feeds only the edge detectors
      toggle_sync_reg <= {toggle_sync_reg[1:0], link.ext_polarity_toggle};
      scs_sync_reg    <= {scs_sync_reg[1:0], link.frame_select};
      src_sync_reg    <= {src_sync_reg[0], link.polarity_source_pin};
      // Mode bits settle before the capture; level crossing is enough
      upd_sync_reg    <= {upd_sync_reg[0], mode_reg[UPDATE_IDX]};
      clr_sync_reg    <= {clr_sync_reg[0], mode_reg[CLEAR_IDX]};
      spol_sync_reg   <= {spol_sync_reg[0], serial_pol_reg};
    end
  end
  assign ext_mode = src_sync_reg[1]; // see RULE_07

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_polarity <= 1'b0;
    // Toggle pulses shorter than one ref_clk cycle can be lost
    end else if (ext_mode && toggle_sync_reg[1] && !toggle_sync_reg[2]) begin
      pending_polarity <= ~pending_polarity; // see RULE_08
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      common_electrode_level <= 1'b0;
    end else if (ext_mode) begin
      // Serial bit ignored here; see RULE_05
      // Fall is seen late, so the level moves only between frames
      if (!scs_sync_reg[1] && scs_sync_reg[2]) begin
        common_electrode_level <= pending_polarity; // see RULE_09
      end
    end else begin
      common_electrode_level <= spol_sync_reg[1]; // see RULE_04
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      update_select_bit <= 1'b0;
      clear_all_bit     <= 1'b0;
      rd_pixels         <= '0;
    end else begin
      update_select_bit <= upd_sync_reg[1];
      clear_all_bit     <= clr_sync_reg[1];
      // Readback is quasi-static; only valid between frames
      rd_pixels <= (rd_line >= FIRST_LINE && rd_line <= LAST_LINE) ?
                   mem_reg[rd_line - FIRST_LINE] : '0;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mlcd_pkg.sv */
package mlcd_pkg;
  localparam int          LINE_COUNT     = 96;
  localparam int          PIXELS_PER_LINE = 96;
  localparam int          ADDR_BITS      = 7;
  localparam int          MODE_BITS      = 3;
  localparam int          MODE_DUMMY_BITS = 5;
  localparam int          LINE_DUMMY_BITS = 8;
  localparam int          FRAME_DUMMY_BITS = 8;
  localparam int          UPDATE_IDX     = 0;
  localparam int          POLARITY_IDX   = 1;
  localparam int          CLEAR_IDX      = 2;
  localparam logic [6:0]  FIRST_LINE     = 7'h01;
  localparam logic [6:0]  LAST_LINE      = 7'h60;
  localparam logic        DUMMY_LEVEL    = 1'b0;
  localparam logic        PIXEL_WHITE    = 1'b1;
  localparam int          HOST_CLK_DIV   = 8;
  localparam int          SCS_GUARD_CYC  = 4;

  typedef enum logic [2:0] {
    MLCD_RX_MODE  = 3'b000,
    MLCD_RX_MDUM  = 3'b001,
    MLCD_RX_ADDR  = 3'b010,
    MLCD_RX_PIX   = 3'b011,
    MLCD_RX_LDUM  = 3'b100
  } mlcd_rx_state_t;

  typedef enum logic [2:0] {
    MLCD_TX_IDLE  = 3'b000,
    MLCD_TX_SETUP = 3'b001,
    MLCD_TX_SHIFT = 3'b010,
    MLCD_TX_TAIL  = 3'b011,
    MLCD_TX_HOLD  = 3'b100
  } mlcd_tx_state_t;
endpackage

/* File: rtl/mlcd_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mlcd_link_if;
  logic frame_select;
  logic serial_clk;
  logic serial_data;
  logic ext_polarity_toggle;
  logic polarity_source_pin;

  modport host (
    output frame_select,
    output serial_clk,
    output serial_data,
    output ext_polarity_toggle,
    output polarity_source_pin
  );
  modport panel (
    input frame_select,
    input serial_clk,
    input serial_data,
    input ext_polarity_toggle,
    input polarity_source_pin
  );
endinterface
`default_nettype wire

/* File: rtl/mlcd_host.sv */
`timescale 1ns/10ps
`default_nettype none
module mlcd_host
  import mlcd_pkg::*;
#(
  parameter int PIXELS = mlcd_pkg::PIXELS_PER_LINE,
  parameter int CLK_DIV = mlcd_pkg::HOST_CLK_DIV
) (
  mlcd_link_if.host              link,
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_update,
  input  wire logic              req_clear,
  input  wire logic              req_polarity,
  input  wire logic [6:0]        req_line,
  input  wire logic [PIXELS-1:0] req_pixels,
  input  wire logic              req_last,
  input  wire logic              ext_mode_sel,
  input  wire logic              ext_toggle_in
);
  import mlcd_pkg::*;

  localparam int FRAME_W = MODE_BITS + MODE_DUMMY_BITS + ADDR_BITS + 1 + PIXELS + LINE_DUMMY_BITS;

  mlcd_tx_state_t         state_reg;
  logic [7:0]             div_reg;
  logic                   sclk_reg;
  logic                   scs_reg;
  logic                   sdata_reg;
  logic [FRAME_W-1:0]     frame_reg;
  logic [7:0]             len_reg;
  logic [7:0]             cnt_reg;
  logic                   tick;
  logic                   in_frame_reg;

  assign tick      = (div_reg == 8'(CLK_DIV - 1));
  assign req_ready = (state_reg == MLCD_TX_IDLE) || (state_reg == MLCD_TX_HOLD && tick && !sclk_reg);

  assign link.frame_select        = scs_reg;
  assign link.serial_clk          = sclk_reg;
  assign link.serial_data         = sdata_reg;
  assign link.polarity_source_pin = ext_mode_sel;       // see RULE_07
  assign link.ext_polarity_toggle = ext_toggle_in;      // see RULE_10

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sender: mode word only on the first line of a frame
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= MLCD_TX_IDLE;
      sclk_reg     <= 1'b0;
      scs_reg      <= 1'b0;
      sdata_reg    <= 1'b0;
      frame_reg    <= '0;
      len_reg      <= 8'h00;
      cnt_reg      <= 8'h00;
      in_frame_reg <= 1'b0;
    end else if (req_valid && req_ready) begin
      // Line layout: 7 address bits LSB first, spare, pixels, dummies low
      frame_reg <= {{LINE_DUMMY_BITS{DUMMY_LEVEL}}, req_pixels, DUMMY_LEVEL,
                    req_line,                                   // see RULE_13
                    {MODE_DUMMY_BITS{DUMMY_LEVEL}},             // see RULE_12
                    req_clear, req_polarity, req_update};       // see RULE_16
      len_reg   <= in_frame_reg ? 8'(FRAME_W - MODE_BITS - MODE_DUMMY_BITS) : 8'(FRAME_W);
      if (in_frame_reg) begin
        frame_reg <= FRAME_W'({{LINE_DUMMY_BITS{DUMMY_LEVEL}}, req_pixels, DUMMY_LEVEL, req_line});
      end
      in_frame_reg <= !req_last;                                // see RULE_15
      cnt_reg      <= 8'h00;
      scs_reg      <= 1'b1;
      state_reg    <= MLCD_TX_SETUP;
    end else if (tick) begin
      unique case (state_reg)
        MLCD_TX_IDLE: begin
          sclk_reg <= 1'b0;
        end
        MLCD_TX_SETUP: begin
          sdata_reg <= frame_reg[0];
          frame_reg <= frame_reg >> 1;
          state_reg <= MLCD_TX_SHIFT;
        end
        MLCD_TX_SHIFT: begin
          if (!sclk_reg) begin
            sclk_reg <= 1'b1;
          end else begin
            sclk_reg <= 1'b0;
            cnt_reg  <= cnt_reg + 8'h01;
            if (cnt_reg == len_reg - 8'h01) begin
              sdata_reg <= DUMMY_LEVEL;
              state_reg <= in_frame_reg ? MLCD_TX_HOLD : MLCD_TX_TAIL;
              cnt_reg   <= 8'h00;
            end else begin
              sdata_reg <= frame_reg[0];
              frame_reg <= frame_reg >> 1;
            end
          end
        end
        MLCD_TX_TAIL: begin
          // Hold frame select a few ticks after the last edge
          if (cnt_reg == 8'(SCS_GUARD_CYC)) begin
            scs_reg   <= 1'b0;
            state_reg <= MLCD_TX_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        MLCD_TX_HOLD: begin
          sclk_reg <= 1'b0;
        end
        default: state_reg <= MLCD_TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verification/mlcd_link_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module mlcd_link_asserts (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic frame_select,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic ext_polarity_toggle,
  input wire logic polarity_source_pin,
  input wire logic common_electrode_level,
  input wire logic update_select_bit,
  input wire logic clear_all_bit
);
  logic        sclk_q, fs_q, src_q, upd_cap, pol_cap, clr_cap;
  logic [11:0] bit_cnt;
  logic [6:0]  addr_cap;
  logic [4:0]  quiet_cnt;
  wire  logic  sclk_rise = serial_clk && !sclk_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      fs_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
      fs_q <= frame_select;
      src_q <= polarity_source_pin;
    end
  end
  // Position counter spans the whole frame, so first-line slots are fixed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) bit_cnt <= 12'h000;
    else if (!frame_select) bit_cnt <= 12'h000;
    else if (sclk_rise) bit_cnt <= bit_cnt + 12'h001;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {upd_cap, pol_cap, clr_cap} <= 3'h0;
      addr_cap <= 7'h00;
    end else if (frame_select && sclk_rise) begin
      if (bit_cnt == 12'h000) upd_cap <= serial_data;
      if (bit_cnt == 12'h001) pol_cap <= serial_data;
      if (bit_cnt == 12'h002) clr_cap <= serial_data;
      if (bit_cnt >= 12'h008 && bit_cnt <= 12'h00E) addr_cap[bit_cnt[2:0]] <= serial_data;
    end
  end
  // Frame or source edges restart the quiet window
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) quiet_cnt <= 5'h00;
    else if (frame_select != fs_q || polarity_source_pin != src_q) quiet_cnt <= 5'h00;
    else if (quiet_cnt != 5'h1F) quiet_cnt <= quiet_cnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_mode_flags_sync: assert property ((sclk_rise && bit_cnt == 12'h003) |-> ##12
    (update_select_bit == upd_cap && clear_all_bit == clr_cap)) else $error("mode flags wrong");
  chk_serial_polarity: assert property ((sclk_rise && bit_cnt == 12'h003 && !polarity_source_pin) |->
    ##12 common_electrode_level == pol_cap) else $error("serial polarity not followed");
  chk_flags_cleared: assert property ($fell(frame_select) |-> ##8
    (!update_select_bit && !clear_all_bit)) else $error("mode flags not cleared");
  chk_ext_level_hold: assert property ((polarity_source_pin && quiet_cnt > 5'h08) |->
    $stable(common_electrode_level)) else $error("electrode moved outside frame fall");
  chk_dummy_bits_low: assert property ((sclk_rise && ((bit_cnt >= 12'h003 && bit_cnt <= 12'h007) ||
    bit_cnt == 12'h00F || (bit_cnt >= 12'h070 && bit_cnt <= 12'h077))) |-> !serial_data)
    else $error("dummy bit not low");
  chk_line_addr_range: assert property ((sclk_rise && bit_cnt == 12'h00F) |->
    (addr_cap >= 7'h01 && addr_cap <= 7'h60)) else $error("line address out of range");
  chk_clk_idle_low: assert property (!frame_select |-> !serial_clk) else $error("serial clock outside frame");
  chk_data_stable: assert property ((frame_select && serial_clk && $past(serial_clk)) |->
    $stable(serial_data)) else $error("data moved while clock high");
  cover property (sclk_rise && bit_cnt == 12'h003 && clr_cap);
  cover property (sclk_rise && bit_cnt == 12'h082);
  cover property ($rose(ext_polarity_toggle) && polarity_source_pin);
endmodule
`default_nettype wire

/* File: verification/memory_lcd_mode_and_polarity_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none
module memory_lcd_mode_and_polarity_ctrl_test;
  import mlcd_pkg::*;
  localparam logic [95:0] PIX_A = 96'hC35A_0F0F_1234_5678_9ABC_DEF1;
  localparam logic [95:0] PIX_B = 96'h0003_FFFF_0000_8421_7E81_0002;
  localparam logic [95:0] ALL_W = {96{PIXEL_WHITE}};
  logic        ref_clk, reset_n, req_valid, req_ready, req_update, req_clear, req_polarity, req_last;
  logic        ext_mode_sel, ext_toggle_in, common_electrode_level, update_select_bit, clear_all_bit, v0;
  logic [6:0]  req_line, rd_line;
  logic [95:0] req_pixels, rd_pixels;
  int          err_total, checked;
  mlcd_link_if link_bus ();
  mlcd_host u_mlcd_host (.link(link_bus.host), .ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_update(req_update), .req_clear(req_clear), .req_polarity(req_polarity),
    .req_line(req_line), .req_pixels(req_pixels), .req_last(req_last), .ext_mode_sel(ext_mode_sel),
    .ext_toggle_in(ext_toggle_in));
  mlcd_panel u_mlcd_panel (.link(link_bus.panel), .ref_clk(ref_clk), .reset_n(reset_n), .rd_line(rd_line),
    .rd_pixels(rd_pixels), .common_electrode_level(common_electrode_level),
    .update_select_bit(update_select_bit), .clear_all_bit(clear_all_bit));
  mlcd_link_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .frame_select(link_bus.frame_select),
    .serial_clk(link_bus.serial_clk), .serial_data(link_bus.serial_data),
    .ext_polarity_toggle(link_bus.ext_polarity_toggle), .polarity_source_pin(link_bus.polarity_source_pin),
    .common_electrode_level(common_electrode_level), .update_select_bit(update_select_bit),
    .clear_all_bit(clear_all_bit));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Mode bits only count on the first line of a frame
  task automatic send(input logic upd, clr, pol, input logic [6:0] line, input logic [95:0] pix, input logic last);
    int n;
    @(negedge ref_clk);
    {req_valid, req_update, req_clear, req_polarity, req_last} = {1'b1, upd, clr, pol, last};
    req_line = line;
    req_pixels = pix;
    // Ready is looked at where it has settled; the next rising edge takes the line
    for (n = 0; n < 5000 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n >= 5000) err_total++;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  // Waits out the frame plus the flag synchroniser
  task automatic wait_fall();
    int n;
    for (n = 0; n < 10000 && link_bus.frame_select !== 1'b0; n++) @(negedge ref_clk);
    if (n >= 10000) err_total++;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic frame(input logic upd, clr, pol, input logic [6:0] line, input logic [95:0] pix);
    send(upd, clr, pol, line, pix, 1'b1);
    wait_fall();
  endtask
  task automatic look(input logic [6:0] line, input logic [95:0] exp);
    @(negedge ref_clk);
    rd_line = line;
    repeat (2) @(negedge ref_clk);
    chk(rd_pixels, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_clear();
    send(1'b0, 1'b1, 1'b0, 7'h01, 96'h0, 1'b1);
    repeat (200) @(negedge ref_clk);
    chk({94'h0, update_select_bit, clear_all_bit}, 96'h1);
    wait_fall();
    look(7'h01, ALL_W);
    look(7'h1E, ALL_W);
    look(7'h60, ALL_W);
    chk({94'h0, update_select_bit, clear_all_bit}, 96'h0);
  endtask
  // Lines 64 and 3 catch a reversed address order
  task automatic t_multi();
    send(1'b1, 1'b0, 1'b0, 7'h01, PIX_A, 1'b0);
    send(1'b1, 1'b0, 1'b0, 7'h60, PIX_B, 1'b1);
    chk({94'h0, update_select_bit, clear_all_bit}, 96'h2);
    wait_fall();
    look(7'h61, 96'h0);
    look(7'h01, PIX_A);
    look(7'h60, PIX_B);
    look(7'h40, ALL_W);
    look(7'h03, ALL_W);
  endtask
  task automatic t_hold();
    frame(1'b0, 1'b0, 1'b0, 7'h01, PIX_B);
    look(7'h01, PIX_A);
  endtask
  task automatic t_serial_pol();
    frame(1'b0, 1'b0, 1'b1, 7'h02, 96'h0);
    chk({95'h0, common_electrode_level}, 96'h1);
    frame(1'b0, 1'b0, 1'b0, 7'h02, 96'h0);
    chk({95'h0, common_electrode_level}, 96'h0);
  endtask
  // Serial bit is sent equal to the old level so following it would show
  task automatic t_ext_pol();
    @(negedge ref_clk);
    ext_mode_sel = 1'b1;
    frame(1'b0, 1'b0, 1'b0, 7'h02, 96'h0);
    v0 = common_electrode_level;
    @(negedge ref_clk);
    ext_toggle_in = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk({95'h0, common_electrode_level}, {95'h0, v0});
    frame(1'b0, 1'b0, v0, 7'h02, 96'h0);
    chk({95'h0, common_electrode_level}, {95'h0, ~v0});
    frame(1'b0, 1'b0, v0, 7'h02, 96'h0);
    chk({95'h0, common_electrode_level}, {95'h0, ~v0});
    ext_toggle_in = 1'b0;
    repeat (20) @(negedge ref_clk);
    ext_toggle_in = 1'b1;
    repeat (20) @(negedge ref_clk);
    frame(1'b0, 1'b0, ~v0, 7'h02, 96'h0);
    chk({95'h0, common_electrode_level}, {95'h0, v0});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checked = 0;
    reset_n = 1'b0;
    {req_valid, req_update, req_clear, req_polarity, req_last, ext_mode_sel, ext_toggle_in} = 7'h00;
    req_line = 7'h01;
    rd_line = 7'h01;
    req_pixels = 96'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_clear();
    t_multi();
    t_hold();
    t_serial_pol();
    t_ext_pol();
    close_out();
  end
  // Whole run is near 20k cycles; the limit is three times that, past it is a hang
  initial begin
    #600000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
